// *** rtl/cimr_pkg.sv ***
// cimr_pkg: shared constants for the indirect-move and return execution block
// assumes: 14-bit instruction words, 15-bit program counter, 16-bit pointers
package cimr_pkg;
   // ==========================================================
   // widths
   localparam int CIMR_PC_W = 15;
   localparam int CIMR_PTR_W = 16;
   localparam int CIMR_IW = 14;
   // ==========================================================
   // opcodes
   localparam logic [13:0] CIMR_OP_NOP = 14'h0000;
   localparam logic [13:0] CIMR_OP_RETURN = 14'h0008;
   localparam logic [13:0] CIMR_OP_RETURN_FROM_INTERRUPT_OP = 14'h0009;
   localparam logic [13:0] CIMR_OP_OPTION = 14'h0062;
   localparam logic [13:0] CIMR_OP_RESET = 14'h0001;
   // indirect moves: 00 0000 0001 0 n mm (read) / 1 n mm (write)
   localparam logic [8:0] CIMR_OP_MOVI_HI = 9'h000;
   localparam int CIMR_DIR_BIT = 3;
   localparam int CIMR_SEL_BIT = 2;
   // ==========================================================
   // pointer update modes
   localparam logic [1:0] CIMR_MM_PREINC = 2'h0;
   localparam logic [1:0] CIMR_MM_PREDEC = 2'h1;
   localparam logic [1:0] CIMR_MM_POSTINC = 2'h2;
   localparam logic [1:0] CIMR_MM_POSTDEC = 2'h3;
   // ==========================================================
   // reset values and register bits
   localparam logic [7:0] CIMR_OPTION_RST = 8'hFF;
   localparam logic [15:0] CIMR_PTR_RST = 16'h0000;
   localparam logic [14:0] CIMR_PC_RST = 15'h0000;
   localparam int CIMR_GIE_BIT = 7;
   // reset-instruction pulse length in cycles
   localparam logic [1:0] CIMR_SWRST_CYC = 2'h2;
   typedef enum logic [1:0] {
      CIMR_S_RUN = 2'b00,
      CIMR_S_BUBBLE = 2'b01,
      CIMR_S_RESET = 2'b10
   } cimr_state_t;
endpackage

// *** rtl/cimr_ptr_unit.sv ***
// cimr_ptr_unit: effective address and updated pointer for an indirect move
// assumes: purely combinational, driven by the decoder
`timescale 1ns/1ns
module cimr_ptr_unit
   import cimr_pkg::*;
(
   input wire logic [CIMR_PTR_W-1:0] ptr,
   input wire logic [1:0] pointer_update_mode,
   output logic [CIMR_PTR_W-1:0] eff_addr,
   output logic [CIMR_PTR_W-1:0] ptr_new
);
   logic [CIMR_PTR_W-1:0] inc;
   logic [CIMR_PTR_W-1:0] dec;
   // ==========================================================
   // arithmetic: modulo 2^16 by truncation
   always_comb begin
      inc = ptr + 16'h0001; // RL3
      dec = ptr - 16'h0001; // RL3
      case (pointer_update_mode) // RL1
         CIMR_MM_PREINC: begin
            eff_addr = inc;
            ptr_new = inc;
         end
         CIMR_MM_PREDEC: begin
            eff_addr = dec;
            ptr_new = dec;
         end
         CIMR_MM_POSTINC: begin
            eff_addr = ptr;
            ptr_new = inc;
         end
         default: begin
            eff_addr = ptr;
            ptr_new = dec;
         end
      endcase
   end
endmodule // cimr_ptr_unit

// *** rtl/cimr_core.sv ***
// cimr_core: executes indirect moves, nop, option, reset, return_from_interrupt_op and return
// assumes: instruction arrives one per cycle from fetch; data memory answers reads combinationally
//
// What this block does
// RL1 - indirect moves pre/post increment or decrement the pointer by mode field
// RL2 - indirect port is not a register; access goes to pointer's address
// RL3 - sixteen-bit pointer wraps modulo 65536 in both directions
// RL4 - pointer update by indirect moves leaves status flags untouched
// RL5 - option instruction copies working register to option register, no flags
// RL6 - reset instruction resets the device and clears reset-instruction flag
// RL7 - interrupt return pops stack into pc, sets enable bit 7, two cycles
// RL8 - subroutine return pops stack into pc, two cycles, no flags
// RL9 - no-op only advances the program counter, one cycle
// RL10 - two-cycle returns flush the prefetched instruction as a bubble
`timescale 1ns/1ns
module cimr_core
   import cimr_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic instr_valid,
   input wire logic [CIMR_IW-1:0] instr,
   input wire logic [7:0] w_reg,
   input wire logic [CIMR_PC_W-1:0] top_of_stack_entry,
   input wire logic [7:0] mem_rdata,
   input wire logic reset_instruction_set,
   output logic [CIMR_PC_W-1:0] pc,
   output logic stack_pop,
   output logic flush,
   output logic [CIMR_PTR_W-1:0] file_select_pointer0,
   output logic [CIMR_PTR_W-1:0] file_select_pointer1,
   output logic [CIMR_PTR_W-1:0] mem_addr,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   output logic w_we,
   output logic [7:0] w_wdata,
   output logic [7:0] option_reg,
   output logic global_interrupt_enable,
   output logic reset_instruction_flag,
   output logic soft_reset_out,
   output logic status_we
);
   import cimr_pkg::*;
   // ==========================================================
   // reset synchroniser
   logic rst_s1_r;
   logic rst_s2_r;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   wire logic rst_n = rst_s2_r;
   // ==========================================================
   // decode
   function automatic logic is_movi(input logic [CIMR_IW-1:0] op);
      is_movi = (op[13:5] == CIMR_OP_MOVI_HI) && (op[4] == 1'b1);
   endfunction
   logic sel;
   logic [CIMR_PTR_W-1:0] cur_ptr;
   logic [CIMR_PTR_W-1:0] eff;
   logic [CIMR_PTR_W-1:0] upd;
   assign sel = instr[CIMR_SEL_BIT];
   assign cur_ptr = sel ? file_select_pointer1 : file_select_pointer0;
   cimr_ptr_unit u_ptr (
      .ptr(cur_ptr),
      .pointer_update_mode(instr[1:0]),
      .eff_addr(eff),
      .ptr_new(upd)
   );
   // ==========================================================
   // state
   cimr_state_t st_r, st_nxt;
   logic [1:0] rcnt_r, rcnt_nxt;
   logic [CIMR_PC_W-1:0] pc_r, pc_nxt;
   logic [CIMR_PTR_W-1:0] fsp0_r, fsp0_nxt, fsp1_r, fsp1_nxt, maddr_r, maddr_nxt;
   logic mwe_r, mwe_nxt, wwe_r, wwe_nxt, pop_r, pop_nxt, flush_r, flush_nxt;
   logic [7:0] mwd_r, mwd_nxt, wwd_r, wwd_nxt, opt_r, opt_nxt;
   logic gie_r, gie_nxt, rif_r, rif_nxt, srst_r, srst_nxt;
   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      rcnt_nxt = rcnt_r;
      pc_nxt = pc_r;
      fsp0_nxt = fsp0_r;
      fsp1_nxt = fsp1_r;
      maddr_nxt = maddr_r;
      mwe_nxt = 1'b0;
      mwd_nxt = mwd_r;
      wwe_nxt = 1'b0;
      wwd_nxt = wwd_r;
      pop_nxt = 1'b0;
      flush_nxt = 1'b0;
      opt_nxt = opt_r;
      gie_nxt = gie_r;
      rif_nxt = rif_r | reset_instruction_set;
      srst_nxt = 1'b0;
      case (st_r)
         CIMR_S_RUN: begin
            if (instr_valid) begin
               pc_nxt = pc_r + 15'h0001; // RL9
               if (is_movi(instr)) begin
                  // address goes straight to memory, no indirect register exists
                  maddr_nxt = eff; // RL2
                  if (instr[CIMR_DIR_BIT]) begin
                     mwe_nxt = 1'b1;
                     mwd_nxt = w_reg;
                  end else begin
                     wwe_nxt = 1'b1;
                     wwd_nxt = mem_rdata;
                  end
                  if (sel) begin
                     fsp1_nxt = upd; // RL1
                  end else begin
                     fsp0_nxt = upd; // RL1
                  end
               end else if (instr == CIMR_OP_OPTION) begin
                  opt_nxt = w_reg; // RL5
               end else if (instr == CIMR_OP_RESET) begin
                  rif_nxt = 1'b0; // RL6
                  srst_nxt = 1'b1; // RL6
                  rcnt_nxt = CIMR_SWRST_CYC;
                  st_nxt = CIMR_S_RESET;
               end else if (instr == CIMR_OP_RETURN || instr == CIMR_OP_RETURN_FROM_INTERRUPT_OP) begin
                  pc_nxt = top_of_stack_entry; // RL8
                  pop_nxt = 1'b1; // RL8
                  flush_nxt = 1'b1; // RL10
                  st_nxt = CIMR_S_BUBBLE; // RL10
                  if (instr == CIMR_OP_RETURN_FROM_INTERRUPT_OP) begin
                     gie_nxt = 1'b1; // RL7
                  end
               end
            end
         end
         CIMR_S_BUBBLE: begin
            // prefetched word is dropped; pc already holds return address
            st_nxt = CIMR_S_RUN; // RL10
         end
         CIMR_S_RESET: begin
            // hold the device reset a couple of cycles so every block sees it
            srst_nxt = 1'b1; // RL6
            rcnt_nxt = rcnt_r - 2'h1;
            pc_nxt = CIMR_PC_RST;
            fsp0_nxt = CIMR_PTR_RST;
            fsp1_nxt = CIMR_PTR_RST;
            opt_nxt = CIMR_OPTION_RST;
            gie_nxt = 1'b0;
            if (rcnt_r == 2'h1) begin
               srst_nxt = 1'b0;
               st_nxt = CIMR_S_RUN;
            end
         end
         default: begin
            st_nxt = CIMR_S_RUN;
         end
      endcase
   end
   // ==========================================================
   // registers; flag survives the soft reset so cause stays readable
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= CIMR_S_RUN;
         rcnt_r <= 2'h0;
         pc_r <= CIMR_PC_RST;
         fsp0_r <= CIMR_PTR_RST;
         fsp1_r <= CIMR_PTR_RST;
         maddr_r <= CIMR_PTR_RST;
         mwe_r <= 1'b0;
         mwd_r <= 8'h00;
         wwe_r <= 1'b0;
         wwd_r <= 8'h00;
         pop_r <= 1'b0;
         flush_r <= 1'b0;
         opt_r <= CIMR_OPTION_RST;
         gie_r <= 1'b0;
         rif_r <= 1'b1;
         srst_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         rcnt_r <= rcnt_nxt;
         pc_r <= pc_nxt;
         fsp0_r <= fsp0_nxt;
         fsp1_r <= fsp1_nxt;
         maddr_r <= maddr_nxt;
         mwe_r <= mwe_nxt;
         mwd_r <= mwd_nxt;
         wwe_r <= wwe_nxt;
         wwd_r <= wwd_nxt;
         pop_r <= pop_nxt;
         flush_r <= flush_nxt;
         opt_r <= opt_nxt;
         gie_r <= gie_nxt;
         rif_r <= rif_nxt;
         srst_r <= srst_nxt;
      end
   end
   // ==========================================================
   // outputs
   assign pc = pc_r;
   assign stack_pop = pop_r;
   assign flush = flush_r;
   assign file_select_pointer0 = fsp0_r;
   assign file_select_pointer1 = fsp1_r;
   assign mem_addr = maddr_r;
   assign mem_we = mwe_r;
   assign mem_wdata = mwd_r;
   assign w_we = wwe_r;
   assign w_wdata = wwd_r;
   assign option_reg = opt_r;
   assign global_interrupt_enable = gie_r;
   assign reset_instruction_flag = rif_r;
   assign soft_reset_out = srst_r;
   // no instruction in this group writes status
   assign status_we = 1'b0; // RL4
endmodule // cimr_core

// *** verification/cimr_core_props.sv ***
// cimr_core_props: port-level assertions for cimr_core
// assumes: one clock, bound onto every cimr_core instance
`timescale 1ns/1ns
module cimr_core_props
   import cimr_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic instr_valid,
   input wire logic [CIMR_IW-1:0] instr,
   input wire logic [7:0] w_reg,
   input wire logic [CIMR_PC_W-1:0] top_of_stack_entry,
   input wire logic [CIMR_PC_W-1:0] pc,
   input wire logic stack_pop,
   input wire logic flush,
   input wire logic [CIMR_PTR_W-1:0] file_select_pointer0,
   input wire logic [CIMR_PTR_W-1:0] file_select_pointer1,
   input wire logic [CIMR_PTR_W-1:0] mem_addr,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] option_reg,
   input wire logic global_interrupt_enable,
   input wire logic reset_instruction_flag,
   input wire logic soft_reset_out,
   input wire logic status_we
);
   // ==============
   // decode helpers
   logic [15:0] cur, nxt, eff;
   logic take, ind;
   assign take = instr_valid && !stack_pop && !soft_reset_out;
   assign ind = take && instr[13:4] == 10'h001;
   always_comb begin
      cur = instr[2] ? file_select_pointer1 : file_select_pointer0;
      nxt = instr[0] ? cur - 16'h0001 : cur + 16'h0001;
      eff = instr[1] ? cur : nxt;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ==============
   // sequences
   sequence ret_seq;
      pc == $past(top_of_stack_entry) && stack_pop && flush;
   endsequence
   sequence sr_seq;
      !reset_instruction_flag && soft_reset_out ##1 soft_reset_out
      ##1 !soft_reset_out && pc == 15'h0000 && !global_interrupt_enable && option_reg == CIMR_OPTION_RST;
   endsequence
   // ==============
   // checks
   ptr_update_a: assert property (ind |=>
      ($past(instr[2]) ? file_select_pointer1 : file_select_pointer0) == $past(nxt)) else $error("pointer update wrong");
   ind_write_a: assert property (ind && instr[3] |=>
      mem_we && mem_addr == $past(eff) && mem_wdata == $past(w_reg)) else $error("indirect write wrong");
   status_quiet_a: assert property (status_we == 1'h0) else $error("status written");
   option_load_a: assert property (take && instr == CIMR_OP_OPTION |=>
      option_reg == $past(w_reg)) else $error("option load wrong");
   soft_reset_a: assert property (take && instr == CIMR_OP_RESET |=> sr_seq) else $error("soft reset wrong");
   int_return_a: assert property (take && instr == CIMR_OP_RETURN_FROM_INTERRUPT_OP |=>
      ret_seq and global_interrupt_enable) else $error("interrupt return wrong");
   sub_return_a: assert property (take && instr == CIMR_OP_RETURN |=>
      ret_seq and $stable(global_interrupt_enable)) else $error("subroutine return wrong");
   nop_idle_a: assert property (take && instr == CIMR_OP_NOP |=> pc == $past(pc) + 15'h0001 && !mem_we
      && $stable(file_select_pointer0) && $stable(file_select_pointer1)) else $error("nop changed state");
   bubble_a: assert property (stack_pop |=> $stable(pc) && !stack_pop) else $error("bubble not held");
endmodule // cimr_core_props

bind cimr_core cimr_core_props u_cimr_core_props (.core_clk, .arst_n, .instr_valid, .instr, .w_reg,
   .top_of_stack_entry, .pc, .stack_pop, .flush, .file_select_pointer0, .file_select_pointer1, .mem_addr,
   .mem_we, .mem_wdata, .option_reg, .global_interrupt_enable, .reset_instruction_flag, .soft_reset_out,
   .status_we);

// *** verification/tb.sv ***
// tb: corner and random instruction stream for cimr_core
// assumes: cimr_pkg and cimr_core compiled first
`timescale 1ns/1ns
module tb;
   import cimr_pkg::*;
   logic core_clk = 0, arst_n = 0, instr_valid = 0, reset_instruction_set = 0;
   logic [13:0] instr = 0;
   logic [7:0] w_reg = 0, mem_rdata = 0, mem_wdata, w_wdata, option_reg;
   logic [14:0] top_of_stack_entry = 0, pc, epc;
   logic [15:0] file_select_pointer0, file_select_pointer1, mem_addr, fp[2];
   logic stack_pop, flush, mem_we, w_we, global_interrupt_enable, reset_instruction_flag, soft_reset_out;
   logic status_we, egie, eflag;
   logic [7:0] eopt;
   int seed = 38861, n_mismatch = 0, tests_run = 0;
   cimr_core u_cimr_core (.core_clk, .arst_n, .instr_valid, .instr, .w_reg, .top_of_stack_entry, .mem_rdata,
      .reset_instruction_set, .pc, .stack_pop, .flush, .file_select_pointer0, .file_select_pointer1, .mem_addr,
      .mem_we, .mem_wdata, .w_we, .w_wdata, .option_reg, .global_interrupt_enable, .reset_instruction_flag,
      .soft_reset_out, .status_we);
   always #20 core_clk = ~core_clk;
   // ==============
   // checking
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test;
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk_state;
      chk(pc, epc);
      chk(file_select_pointer0, fp[0]);
      chk(file_select_pointer1, fp[1]);
      chk(option_reg, eopt);
      chk(global_interrupt_enable, egie);
      chk(reset_instruction_flag, eflag);
      chk(status_we, 16'h0000);
   endtask
   // pointer after the move: mode bit 0 picks decrement, wraps at 16 bits
   function automatic logic [15:0] ptr_after(input logic [15:0] p, input logic [1:0] mode);
      ptr_after = mode[0] ? p - 16'h0001 : p + 16'h0001;
   endfunction
   // address used: mode bit 1 set means post-update, so the old pointer
   function automatic logic [15:0] addr_used(input logic [15:0] p, input logic [1:0] mode);
      addr_used = mode[1] ? p : ptr_after(p, mode);
   endfunction
   // ==============
   // stimulus
   task hrst;
      @(posedge core_clk);
      arst_n <= 0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1;
      epc = 0; fp[0] = 0; fp[1] = 0; eopt = CIMR_OPTION_RST; egie = 0; eflag = 1;
      repeat (2) @(posedge core_clk);
      #1 chk_state;
   endtask
   task run(input logic [13:0] op);
      logic [15:0] p, np, ea;
      logic [7:0] wv, rv;
      logic [14:0] tv;
      logic ind, ret, rs;
      @(posedge core_clk);
      wv = $random(seed); rv = $random(seed); tv = $random(seed);
      rs = op != CIMR_OP_RESET && ($random(seed) & 7) == 0;
      instr <= op; instr_valid <= 1; w_reg <= wv; mem_rdata <= rv; top_of_stack_entry <= tv;
      reset_instruction_set <= rs;
      ind = op[13:4] == 10'h001;
      ret = op == CIMR_OP_RETURN || op == CIMR_OP_RETURN_FROM_INTERRUPT_OP;
      p = fp[op[2]];
      np = ptr_after(p, op[1:0]);
      ea = addr_used(p, op[1:0]);
      @(posedge core_clk);
      reset_instruction_set <= 0;
      // a return gets a nop in its bubble, which must not advance pc
      if (ret) instr <= CIMR_OP_NOP;
      else instr_valid <= 0;
      epc = ret ? tv : epc + 15'h0001;
      eflag = eflag | rs;
      if (ind) fp[op[2]] = np;
      if (op == CIMR_OP_OPTION) eopt = wv;
      if (op == CIMR_OP_RETURN_FROM_INTERRUPT_OP) egie = 1;
      #1;
      if (ind) chk(mem_addr, ea);
      if (ind && op[3]) chk({mem_we, mem_wdata}, {1'h1, wv});
      if (ind && !op[3]) chk({w_we, mem_we, w_wdata}, {2'h2, rv});
      if (ret) chk({stack_pop, flush}, 2'h3);
      if (!ret) chk({stack_pop, flush}, 2'h0);
      if (!ind) chk({w_we, mem_we}, 2'h0);
      if (op == CIMR_OP_RESET) begin
         eflag = 0;
         chk({reset_instruction_flag, soft_reset_out}, 2'h1);
         repeat (2) @(posedge core_clk);
         #1 epc = 0; fp[0] = 0; fp[1] = 0; eopt = CIMR_OPTION_RST; egie = 0;
         chk(soft_reset_out, 16'h0000);
      end
      chk_state;
      if (ret) begin
         @(posedge core_clk);
         instr_valid <= 0;
         #1 chk_state;
      end
   endtask
   logic [13:0] ops[4] = '{CIMR_OP_NOP, CIMR_OP_OPTION, CIMR_OP_RETURN, CIMR_OP_RETURN_FROM_INTERRUPT_OP};
   initial begin
      hrst;
      // wrap both ways from zero, then every mode, select and direction
      run(14'h0019);
      run(14'h0018);
      run(14'h001F);
      run(14'h0016);
      for (int i = 0; i < 16; i++) run(14'h0010 | 14'(i));
      foreach (ops[i]) run(ops[i]);
      run(CIMR_OP_RESET);
      for (int i = 0; i < 150; i++) begin
         if (($random(seed) & 1) == 0) run(ops[$random(seed) & 3]);
         else run(14'h0010 | 14'($random(seed) & 15));
      end
      run(CIMR_OP_RETURN_FROM_INTERRUPT_OP);
      hrst;
      run(CIMR_OP_RESET);
      run(CIMR_OP_RETURN);
      finish_test;
   end
endmodule // tb
